// file: sjs_pkg.sv
package sjs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_JOG_SPEED = 8'h00;
	localparam logic [7:0] REG_ACC_RATE = 8'h04;
	localparam logic [7:0] REG_DEC_RATE = 8'h08;
	localparam logic [7:0] REG_PRESS_TIME = 8'h0C;
	localparam logic [7:0] REG_PRESS_TRAVEL = 8'h10;
	localparam logic [7:0] REG_STEP_SPEED = 8'h14;
	localparam logic [7:0] REG_PRESS_SPEED = 8'h18;
	localparam logic [7:0] REG_PROG_INDEX = 8'h1C;
	localparam logic [7:0] REG_PROG_DATA = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_NV_SAVE = 8'h28;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [31:0] JOG_SPEED_RST = 32'h000007D0;
	localparam logic [31:0] JOG_SPEED_MIN = 32'h00000001;
	localparam logic [31:0] JOG_SPEED_MAX = 32'h05F5E0FF;
	localparam logic [31:0] ACC_RATE_RST = 32'h00000064;
	localparam logic [31:0] DEC_RATE_RST = 32'h00000064;
	localparam logic [31:0] PRESS_TIME_RST = 32'h00000064;
	localparam logic [31:0] PRESS_TRAVEL_RST = 32'h00001388;
	localparam logic [31:0] STEP_SPEED_RST = 32'h000003E8;
	localparam logic [31:0] PRESS_SPEED_RST = 32'h00000064;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned SEL_W = 6;
	localparam int unsigned PROG_PRESS_BIT = 31;
	localparam int unsigned IN_W = 12;
	localparam int unsigned IN_MODE = 0;
	localparam int unsigned IN_START = 1;
	localparam int unsigned IN_STOP = 2;
	localparam int unsigned IN_JOG_FWD = 3;
	localparam int unsigned IN_JOG_REV = 4;
	localparam int unsigned IN_CONTACT = 5;
	localparam int unsigned IN_SEL_LSB = 6;
	localparam int unsigned ST_BUSY_BIT = 8;
	localparam int unsigned ST_REACHED_BIT = 9;
	localparam int unsigned ST_ECHO_LSB = 16;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_RUN = 8'h02,
		ST_STOP_DEC = 8'h04,
		ST_HELD = 8'h08,
		ST_PRESS_MOVE = 8'h10,
		ST_PRESS_HOLD = 8'h20,
		ST_JOG = 8'h40,
		ST_JOG_DEC = 8'h80
	} sjs_state_t;

	localparam logic [7:0] BUSY_MASK = 8'hF6;

endpackage : sjs_pkg

// file: sjs_sync.sv
`timescale 1ns/1ps
module sjs_sync #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// ----------------------------------------------------------------
	// Two-flop chain per bit; the first flop feeds only the second
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge clk_i)
			begin
				if (!rst_n_i)
				begin
					meta_ff[g] <= 1'b0;
					sync_ff[g] <= 1'b0;
				end
				else
				begin
					meta_ff[g] <= async_i[g];
					sync_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_ff;

endmodule : sjs_sync

// file: sjs_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// - Start in step mode begins the selected step and echoes its number.
// - Stop during a step, except in the pressing hold, decelerates to standstill, then busy falls.
// - Releasing stop resumes the interrupted step toward the original target.
// - Releasing stop during its deceleration abandons the stop and resumes.
// - Target reached rises when the step completes at its target.
// - Pressing step moves to pressing start, then up to pressing travel.
// - After contact and pressing time, target reached rises, step ends.
// - Forward jog moves forward at jog speed using the acceleration rate.
// - Reverse jog moves in reverse at jog speed using the acceleration rate.
// - Jog release decelerates to standstill at the deceleration rate.
// - Busy stays high during jog until standstill after release.
// - Jog speed accepts 1 to 99,999,999, defaults 2,000, applies at once.
// - Exactly one jog speed, shared by both directions.
// - Jog speed edits stay volatile until an explicit nonvolatile save.
// - A new start during a running step cancels it and runs the new one.
module sjs_sequencer
	import sjs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = TICK_CYCLES,
	parameter int unsigned PROG_DEPTH = 64
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Contact inputs, active high
	input wire logic mode_sel_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [SEL_W-1:0] step_select_lines_i,
	input wire logic jog_forward_input_i,
	input wire logic jog_reverse_input_i,
	input wire logic press_contact_i,
	// Contact outputs, active high
	output logic busy_o,
	output logic target_reached_o,
	output logic [SEL_W-1:0] step_echo_outputs_o,
	// Motion command
	output logic [31:0] motor_speed_o,
	output logic motor_reverse_o,
	// Nonvolatile jog speed image
	input wire logic [31:0] nv_jog_speed_i,
	output logic nv_save_o,
	output logic [31:0] nv_jog_speed_o
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] ramp(input logic [31:0] cur,
		input logic [31:0] tgt, input logic [31:0] acc,
		input logic [31:0] dec);
		logic [31:0] r;
		r = tgt;
		if (cur < tgt && tgt - cur > acc)
			r = cur + acc;
		else if (cur > tgt && cur - tgt > dec)
			r = cur - dec;
		return r;
	endfunction : ramp

	function automatic logic [31:0] cap(input logic [31:0] a,
		input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction : cap

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = wr[i*8 +: 8];
		return r;
	endfunction : merge

	// ----------------------------------------------------------------
	// Contact synchronisers
	// ----------------------------------------------------------------
	logic [IN_W-1:0] in_async;
	logic [IN_W-1:0] in_sync;

	assign in_async = {step_select_lines_i, press_contact_i,
		jog_reverse_input_i, jog_forward_input_i, stop_i, start_i,
		mode_sel_i};

	sjs_sync #(
		.WIDTH(IN_W)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i(in_async),
		.sync_o(in_sync)
	);

	logic start_d_ff;
	wire mode_step = in_sync[IN_MODE];
	wire stop_req = in_sync[IN_STOP];
	wire contact = in_sync[IN_CONTACT];
	wire [SEL_W-1:0] sel_now = in_sync[IN_SEL_LSB +: SEL_W];
	wire start_rise = in_sync[IN_START] & ~start_d_ff;
	// Both jog inputs at once cancel each other
	wire jog_one = in_sync[IN_JOG_FWD] ^ in_sync[IN_JOG_REV];
	wire jog_dir_rev = in_sync[IN_JOG_REV];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] jog_speed_ff;
	logic [31:0] acc_rate_ff;
	logic [31:0] dec_rate_ff;
	logic [31:0] press_time_ff;
	logic [31:0] press_travel_ff;
	logic [31:0] step_speed_ff;
	logic [31:0] press_speed_ff;
	logic [SEL_W-1:0] prog_idx_ff;
	logic [31:0] prog_mem [PROG_DEPTH];
	logic nv_loaded_ff;
	logic nv_save_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;

	sjs_state_t state_ff, nxt_state;
	logic [31:0] speed_ff, nxt_speed;
	logic [31:0] remain_ff, nxt_remain;
	logic [31:0] hold_ff, nxt_hold;
	logic press_step_ff, nxt_press_step;
	logic press_phase_ff, nxt_press_phase;
	logic reached_ff, nxt_reached;
	logic rev_ff, nxt_rev;
	logic [SEL_W-1:0] echo_ff, nxt_echo;
	logic [31:0] tick_cnt_ff;

	// ----------------------------------------------------------------
	// Wishbone decode
	// ----------------------------------------------------------------
	wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire wr = req & wb_we_i;
	wire [31:0] jog_wr = merge(jog_speed_ff, wb_dat_i, wb_sel_i);
	// Out-of-range jog speeds are dropped, the old value stays
	wire jog_ok = jog_wr >= JOG_SPEED_MIN && jog_wr <= JOG_SPEED_MAX;
	wire nv_ok = nv_jog_speed_i >= JOG_SPEED_MIN &&
		nv_jog_speed_i <= JOG_SPEED_MAX;
	wire [31:0] status_word = {8'h00, 2'b00, echo_ff, 6'h00, reached_ff,
		busy_o, state_ff};
	logic [31:0] rmux;

	always_comb
	begin
		rmux = 32'h00000000;
		if (wb_adr_i == REG_JOG_SPEED)
			rmux = jog_speed_ff;
		else if (wb_adr_i == REG_ACC_RATE)
			rmux = acc_rate_ff;
		else if (wb_adr_i == REG_DEC_RATE)
			rmux = dec_rate_ff;
		else if (wb_adr_i == REG_PRESS_TIME)
			rmux = press_time_ff;
		else if (wb_adr_i == REG_PRESS_TRAVEL)
			rmux = press_travel_ff;
		else if (wb_adr_i == REG_STEP_SPEED)
			rmux = step_speed_ff;
		else if (wb_adr_i == REG_PRESS_SPEED)
			rmux = press_speed_ff;
		else if (wb_adr_i == REG_PROG_INDEX)
			rmux = {26'h0, prog_idx_ff};
		else if (wb_adr_i == REG_PROG_DATA)
			rmux = prog_mem[prog_idx_ff];
		else if (wb_adr_i == REG_STATUS)
			rmux = status_word;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			nv_save_ff <= 1'b0;
		end
		else
		begin
			ack_ff <= req;
			if (req)
				rdata_ff <= rmux;
			nv_save_ff <= wr && wb_adr_i == REG_NV_SAVE && wb_dat_i[0];
		end
	end

	// Working jog speed: volatile; loaded from the saved image after reset
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			jog_speed_ff <= JOG_SPEED_RST;
			nv_loaded_ff <= 1'b0;
		end
		else
		begin
			nv_loaded_ff <= 1'b1;
			if (!nv_loaded_ff && nv_ok)
				jog_speed_ff <= nv_jog_speed_i;
			else if (wr && wb_adr_i == REG_JOG_SPEED && jog_ok)
				jog_speed_ff <= jog_wr;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			acc_rate_ff <= ACC_RATE_RST;
			dec_rate_ff <= DEC_RATE_RST;
			press_time_ff <= PRESS_TIME_RST;
			press_travel_ff <= PRESS_TRAVEL_RST;
			step_speed_ff <= STEP_SPEED_RST;
			press_speed_ff <= PRESS_SPEED_RST;
			prog_idx_ff <= '0;
		end
		else if (wr)
		begin
			if (wb_adr_i == REG_ACC_RATE)
				acc_rate_ff <= merge(acc_rate_ff, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == REG_DEC_RATE)
				dec_rate_ff <= merge(dec_rate_ff, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == REG_PRESS_TIME)
				press_time_ff <= merge(press_time_ff, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == REG_PRESS_TRAVEL)
				press_travel_ff <= merge(press_travel_ff, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == REG_STEP_SPEED)
				step_speed_ff <= merge(step_speed_ff, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == REG_PRESS_SPEED)
				press_speed_ff <= merge(press_speed_ff, wb_dat_i, wb_sel_i);
			else if (wb_adr_i == REG_PROG_INDEX && wb_sel_i[0])
				prog_idx_ff <= wb_dat_i[SEL_W-1:0];
		end
	end

	// Step table has no reset; software loads it before use
	always_ff @(posedge clk_i)
	begin
		if (wr && wb_adr_i == REG_PROG_DATA)
			prog_mem[prog_idx_ff] <= merge(prog_mem[prog_idx_ff], wb_dat_i,
				wb_sel_i);
	end

	// ----------------------------------------------------------------
	// Profile tick
	// ----------------------------------------------------------------
	wire tick = tick_cnt_ff == 32'(TICK_CYCLES_P - 1);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			tick_cnt_ff <= 32'h00000000;
		else
			tick_cnt_ff <= tick ? 32'h00000000 : tick_cnt_ff + 32'h00000001;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	wire [31:0] mv_target = press_phase_ff ? press_speed_ff : step_speed_ff;
	// Speed never exceeds what is left, so the step lands exactly
	wire [31:0] mv_speed = cap(ramp(speed_ff, mv_target, acc_rate_ff,
		dec_rate_ff), remain_ff);
	wire [31:0] stop_speed = cap(ramp(speed_ff, 32'h00000000, acc_rate_ff,
		dec_rate_ff), remain_ff);
	wire [31:0] jog_speed_nxt = ramp(speed_ff, jog_speed_ff, acc_rate_ff,
		dec_rate_ff);
	wire [31:0] jog_stop_nxt = ramp(speed_ff, 32'h00000000, acc_rate_ff,
		dec_rate_ff);
	wire [31:0] prog_word = prog_mem[sel_now];
	wire resume_press = press_phase_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_speed = speed_ff;
		nxt_remain = remain_ff;
		nxt_hold = hold_ff;
		nxt_press_step = press_step_ff;
		nxt_press_phase = press_phase_ff;
		nxt_reached = reached_ff;
		nxt_rev = rev_ff;
		nxt_echo = echo_ff;
		case (state_ff)
			ST_IDLE:
				if (!mode_step && jog_one)
				begin
					nxt_state = ST_JOG;
					nxt_rev = jog_dir_rev;
					nxt_reached = 1'b0;
				end
			ST_RUN, ST_PRESS_MOVE:
				if (stop_req)
					nxt_state = ST_STOP_DEC;
				else if (state_ff == ST_PRESS_MOVE && contact)
				begin
					nxt_state = ST_PRESS_HOLD;
					nxt_speed = 32'h00000000;
					nxt_hold = 32'h00000000;
				end
				else if (tick)
				begin
					nxt_speed = mv_speed;
					nxt_remain = remain_ff - mv_speed;
					if (remain_ff == mv_speed)
					begin
						if (press_step_ff && !press_phase_ff)
						begin
							nxt_press_phase = 1'b1;
							nxt_remain = press_travel_ff;
							nxt_state = ST_PRESS_MOVE;
						end
						else
						begin
							nxt_state = ST_IDLE;
							nxt_speed = 32'h00000000;
							nxt_reached = 1'b1;
						end
					end
				end
			ST_PRESS_HOLD:
				if (tick)
				begin
					nxt_hold = hold_ff + 32'h00000001;
					if (nxt_hold >= press_time_ff)
					begin
						nxt_state = ST_IDLE;
						nxt_reached = 1'b1;
					end
				end
			ST_STOP_DEC:
				if (!stop_req)
					nxt_state = resume_press ? ST_PRESS_MOVE : ST_RUN;
				else if (tick)
				begin
					nxt_speed = stop_speed;
					nxt_remain = remain_ff - stop_speed;
					if (stop_speed == 32'h00000000)
						nxt_state = ST_HELD;
				end
			ST_HELD:
				if (!stop_req)
					nxt_state = resume_press ? ST_PRESS_MOVE : ST_RUN;
			ST_JOG:
				if (mode_step || !jog_one || jog_dir_rev != rev_ff)
					nxt_state = ST_JOG_DEC;
				else if (tick)
					nxt_speed = jog_speed_nxt;
			ST_JOG_DEC:
				if (tick)
				begin
					nxt_speed = jog_stop_nxt;
					if (jog_stop_nxt == 32'h00000000)
						nxt_state = ST_IDLE;
				end
			default:
				nxt_state = ST_IDLE;
		endcase
		// A new start overrides any step state and captures the select
		if (mode_step && start_rise && state_ff != ST_JOG &&
			state_ff != ST_JOG_DEC)
		begin
			nxt_state = ST_RUN;
			nxt_echo = sel_now;
			nxt_remain = {1'b0, prog_word[30:0]};
			nxt_press_step = prog_word[PROG_PRESS_BIT];
			nxt_press_phase = 1'b0;
			nxt_reached = 1'b0;
			nxt_rev = 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= ST_IDLE;
			speed_ff <= 32'h00000000;
			remain_ff <= 32'h00000000;
			hold_ff <= 32'h00000000;
			press_step_ff <= 1'b0;
			press_phase_ff <= 1'b0;
			reached_ff <= 1'b0;
			rev_ff <= 1'b0;
			echo_ff <= '0;
			start_d_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			speed_ff <= nxt_speed;
			remain_ff <= nxt_remain;
			hold_ff <= nxt_hold;
			press_step_ff <= nxt_press_step;
			press_phase_ff <= nxt_press_phase;
			reached_ff <= nxt_reached;
			rev_ff <= nxt_rev;
			echo_ff <= nxt_echo;
			start_d_ff <= in_sync[IN_START];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign busy_o = |(state_ff & BUSY_MASK);
	assign target_reached_o = reached_ff;
	assign step_echo_outputs_o = echo_ff;
	assign motor_speed_o = speed_ff;
	assign motor_reverse_o = rev_ff;
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign nv_save_o = nv_save_ff;
	assign nv_jog_speed_o = jog_speed_ff;

endmodule : sjs_sequencer

// file: sjs_sva.sv
`timescale 1ns/1ps
module sjs_sva
	import sjs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic wb_ack_o,
	// Contacts
	input wire logic mode_sel_i,
	input wire logic start_i,
	input wire logic jog_forward_input_i,
	input wire logic jog_reverse_input_i,
	input wire logic busy_o,
	input wire logic target_reached_o,
	input wire logic [SEL_W-1:0] step_echo_outputs_o,
	// Motion and jog speed
	input wire logic [31:0] motor_speed_o,
	input wire logic nv_save_o,
	input wire logic [31:0] nv_jog_speed_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held past one cycle");
	ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	start_busy_a: assert property ($rose(start_i) && mode_sel_i
		&& !busy_o && !jog_forward_input_i && !jog_reverse_input_i
		|-> ##[1:4] busy_o)
		else $error("busy late after start");
	echo_start_a: assert property ($changed(step_echo_outputs_o)
		|-> start_i && mode_sel_i)
		else $error("echo changed without start");
	tgt_clear_a: assert property ($fell(target_reached_o)
		|-> start_i || jog_forward_input_i || jog_reverse_input_i)
		else $error("target reached dropped without command");
	tgt_idle_a: assert property (target_reached_o |-> !busy_o)
		else $error("target reached while busy");
	idle_speed_a: assert property (!busy_o |-> motor_speed_o == 32'h0)
		else $error("motor moving while not busy");
	save_cause_a: assert property ($rose(nv_save_o)
		|-> $past(wb_we_i && wb_adr_i == REG_NV_SAVE))
		else $error("save pulse without save write");
	jog_keep_a: assert property ($changed(nv_jog_speed_o)
		&& $past(rst_n_i, 3)
		|-> $past(wb_cyc_i && wb_we_i && wb_adr_i == REG_JOG_SPEED))
		else $error("jog speed changed without write");
endmodule : sjs_sva

// file: sjs_host.sv
`timescale 1ns/1ps
module sjs_host #(
	parameter int HOLD = 8
) (
	// Clock
	input wire logic clk_i,
	// Device status
	input wire logic busy_i,
	// Contact commands
	output logic mode_sel_o,
	output logic start_o,
	output logic stop_o,
	output logic [5:0] sel_o,
	output logic jog_fwd_o,
	output logic jog_rev_o,
	output logic contact_o
);
	initial
	begin
		mode_sel_o = 1'b1;
		start_o = 1'b0;
		stop_o = 1'b0;
		sel_o = 6'h00;
		jog_fwd_o = 1'b0;
		jog_rev_o = 1'b0;
		contact_o = 1'b0;
	end

	// Extra hold lets the bench play a slow controller
	task go_step(input logic [5:0] n, input int extra);
		int i;
		@(posedge clk_i);
		mode_sel_o <= 1'b1;
		sel_o <= n;
		repeat (3) @(posedge clk_i);
		start_o <= 1'b1;
		repeat (HOLD + extra) @(posedge clk_i);
		for (i = 0; i < 50 && busy_i !== 1'b1; i++)
			@(posedge clk_i);
		start_o <= 1'b0;
	endtask : go_step

	task jog(input logic f, input logic r);
		@(posedge clk_i);
		mode_sel_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		jog_fwd_o <= f;
		jog_rev_o <= r;
	endtask : jog

	task pins(input logic s, input logic c, input logic [5:0] n);
		@(posedge clk_i);
		stop_o <= s;
		contact_o <= c;
		sel_o <= n;
	endtask : pins
endmodule : sjs_host

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
	import sjs_pkg::*;
	localparam int TK = 4;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [3:0] bsel = 4'hF;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] nv_jog_speed_i = 32'h00000BB8;
	logic [31:0] wb_dat_o, motor_speed_o, nv_jog_speed_o, rd, js, v;
	logic wb_ack_o, busy_o, target_reached_o, motor_reverse_o, nv_save_o;
	logic mode_sel_i, start_i, stop_i, press_contact_i;
	logic jog_forward_input_i, jog_reverse_input_i;
	logic [5:0] step_select_lines_i, step_echo_outputs_o, s;
	logic saw_save = 1'b0;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	int k;

	sjs_sequencer #(.TICK_CYCLES_P(TK)) sjs_sequencer_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .mode_sel_i(mode_sel_i), .start_i(start_i),
		.stop_i(stop_i), .step_select_lines_i(step_select_lines_i),
		.jog_forward_input_i(jog_forward_input_i),
		.jog_reverse_input_i(jog_reverse_input_i),
		.press_contact_i(press_contact_i), .busy_o(busy_o),
		.target_reached_o(target_reached_o),
		.step_echo_outputs_o(step_echo_outputs_o),
		.motor_speed_o(motor_speed_o), .motor_reverse_o(motor_reverse_o),
		.nv_jog_speed_i(nv_jog_speed_i), .nv_save_o(nv_save_o),
		.nv_jog_speed_o(nv_jog_speed_o));

	sjs_host #(.HOLD(2 * TK)) sjs_host_inst (
		.clk_i(clk_i), .busy_i(busy_o), .mode_sel_o(mode_sel_i),
		.start_o(start_i), .stop_o(stop_i), .sel_o(step_select_lines_i),
		.jog_fwd_o(jog_forward_input_i), .jog_rev_o(jog_reverse_input_i),
		.contact_o(press_contact_i));

	initial
	begin
		forever #20 clk_i = ~clk_i;
	end

	// Hang guard, well above the expected run length
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (nv_save_o === 1'b1)
			saw_save <= 1'b1;
		if (cycles == 40000)
		begin
			n_errors++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] m);
		for (int b = 0; b < 4; b++)
			if (m[b])
				o[8*b+:8] = n[8*b+:8];
		return o;
	endfunction : merge

	function automatic logic [31:0] jog_exp(input logic [31:0] o,
		input logic [31:0] n);
		return (n >= 32'h1 && n <= JOG_SPEED_MAX) ? n : o;
	endfunction : jog_exp

	task check(input string what, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= bsel;
		do
		begin
			@(posedge clk_i);
			i++;
		end
		while (wb_ack_o !== 1'b1 && i < 20);
		rd = wb_dat_o;
		check("bus ack", 32'h1, {31'h0, wb_ack_o});
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task prog(input logic [5:0] n, input logic p, input logic [30:0] d);
		wb(1'b1, REG_PROG_INDEX, {26'h0, n});
		wb(1'b1, REG_PROG_DATA, {p, d});
	endtask : prog

	task wait_sig(input string what, input int w, input logic e);
		int i;
		for (i = 0; i < 3000 && (w ? target_reached_o : busy_o) !== e; i++)
			@(posedge clk_i);
		check(what, {31'h0, e}, {31'h0, w ? target_reached_o : busy_o});
	endtask : wait_sig

	task poll(input logic [7:0] st);
		int i;
		i = 0;
		do
		begin
			wb(1'b0, REG_STATUS, 32'h0);
			i++;
		end
		while (rd[7:0] !== st && i < 300);
		check("state", {24'h0, st}, {24'h0, rd[7:0]});
	endtask : poll

	task results();
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		k = $urandom(30618);
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		wb(1'b0, REG_JOG_SPEED, 32'h0);
		check("restored jog speed", 32'h00000BB8, rd);
		wb(1'b0, REG_STATUS, 32'h0);
		check("idle status", {24'h0, 8'(ST_IDLE)}, rd);
		wb(1'b0, 8'h3C, 32'h0);
		check("unmapped read", 32'h0, rd);
		js = 32'h00000BB8;
		for (k = 0; k < 8; k++)
		begin
			v = k == 0 ? 32'h0 : k == 1 ? JOG_SPEED_MAX + 1 :
				k == 2 ? JOG_SPEED_MAX : k == 3 ? 32'h1 : $urandom % 32'h08000000;
			bsel = k < 4 ? 4'hF : 4'($urandom);
			js = jog_exp(js, merge(js, v, bsel));
			wb(1'b1, REG_JOG_SPEED, v);
			bsel = 4'hF;
			wb(1'b0, REG_JOG_SPEED, 32'h0);
			check("jog speed", js, rd);
			check("working jog speed", js, nv_jog_speed_o);
		end
		js = 32'h6;
		wb(1'b1, REG_JOG_SPEED, js);
		wb(1'b1, REG_NV_SAVE, 32'h1);
		repeat (2) @(posedge clk_i);
		check("save pulse", 32'h1, {31'h0, saw_save});
		check("saved image", js, nv_jog_speed_o);
		wb(1'b1, REG_ACC_RATE, 32'h2);
		wb(1'b1, REG_DEC_RATE, 32'h2);
		wb(1'b1, REG_STEP_SPEED, 32'h4);
		wb(1'b1, REG_PRESS_SPEED, 32'h1);
		wb(1'b1, REG_PRESS_TRAVEL, 32'h14);
		wb(1'b1, REG_PRESS_TIME, 32'h3);
		s = 6'(4 + $urandom % 60);
		prog(s, 1'b0, 31'(20 + $urandom % 60));
		prog(6'h02, 1'b0, 31'h190);
		prog(6'h01, 1'b1, 31'h1E);
		// Plain step, select lines moved after capture
		sjs_host_inst.go_step(s, $urandom % 8);
		check("echo", {26'h0, s}, {26'h0, step_echo_outputs_o});
		sjs_host_inst.pins(1'b0, 1'b0, ~s);
		wait_sig("target reached", 1, 1'b1);
		check("echo held", {26'h0, s}, {26'h0, step_echo_outputs_o});
		// Stop to standstill, then resume
		sjs_host_inst.go_step(6'h02, 0);
		repeat (10 * TK) @(posedge clk_i);
		sjs_host_inst.pins(1'b1, 1'b0, 6'h02);
		wait_sig("busy after stop", 0, 1'b0);
		check("speed held", 32'h0, motor_speed_o);
		check("not reached", 32'h0, {31'h0, target_reached_o});
		sjs_host_inst.pins(1'b0, 1'b0, 6'h02);
		wait_sig("busy on resume", 0, 1'b1);
		wait_sig("resumed target", 1, 1'b1);
		// Stop dropped while still decelerating
		sjs_host_inst.go_step(6'h02, 0);
		repeat (10 * TK) @(posedge clk_i);
		sjs_host_inst.pins(1'b1, 1'b0, 6'h02);
		// Long enough for one tick of braking, too short to reach standstill
		repeat (TK) @(posedge clk_i);
		sjs_host_inst.pins(1'b0, 1'b0, 6'h02);
		repeat (4) @(posedge clk_i);
		check("busy kept", 32'h1, {31'h0, busy_o});
		wait_sig("target after abandon", 1, 1'b1);
		// New start cancels the running step
		sjs_host_inst.go_step(6'h02, 0);
		repeat (5 * TK) @(posedge clk_i);
		sjs_host_inst.go_step(s, 3);
		check("new echo", {26'h0, s}, {26'h0, step_echo_outputs_o});
		wait_sig("new step target", 1, 1'b1);
		// Pressing step
		sjs_host_inst.go_step(6'h01, 0);
		poll(ST_PRESS_MOVE);
		sjs_host_inst.pins(1'b0, 1'b1, 6'h01);
		poll(ST_PRESS_HOLD);
		check("press not done", 32'h0, {31'h0, target_reached_o});
		check("press speed", 32'h0, motor_speed_o);
		wait_sig("press target", 1, 1'b1);
		sjs_host_inst.pins(1'b0, 1'b0, 6'h01);
		// Jog both ways with one shared speed
		for (k = 0; k < 2; k++)
		begin
			sjs_host_inst.jog(k == 0, k == 1);
			repeat (8 * TK) @(posedge clk_i);
			check("jog speed out", js, motor_speed_o);
			check("direction", 32'(k), {31'h0, motor_reverse_o});
			check("jog busy", 32'h1, {31'h0, busy_o});
			sjs_host_inst.jog(1'b0, 1'b0);
			// Let the release pass the synchroniser so braking has begun
			repeat (4) @(posedge clk_i);
			check("busy in decel", 32'h1, {31'h0, busy_o});
			wait_sig("jog stopped", 0, 1'b0);
			check("jog standstill", 32'h0, motor_speed_o);
		end
		sjs_host_inst.jog(1'b1, 1'b0);
		repeat (8 * TK) @(posedge clk_i);
		sjs_host_inst.jog(1'b1, 1'b1);
		wait_sig("both jog stop", 0, 1'b0);
		check("both jog speed", 32'h0, motor_speed_o);
		sjs_host_inst.jog(1'b0, 1'b0);
		results();
	end
endmodule : testbench

bind sjs_sequencer sjs_sva sjs_sva_inst (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_ack_o(wb_ack_o), .mode_sel_i(mode_sel_i), .start_i(start_i),
	.jog_forward_input_i(jog_forward_input_i),
	.jog_reverse_input_i(jog_reverse_input_i), .busy_o(busy_o),
	.target_reached_o(target_reached_o),
	.step_echo_outputs_o(step_echo_outputs_o),
	.motor_speed_o(motor_speed_o), .nv_save_o(nv_save_o),
	.nv_jog_speed_o(nv_jog_speed_o));
